/* File: olc_cfg.svh */
// register map, field positions, function codes and timing of the output logic combiner
`ifndef OLC_CFG_SVH
`define OLC_CFG_SVH

`define OLC_ADDR_W 8
`define OLC_REG_UNIT_FIRST 8'h00
`define OLC_REG_UNIT_LAST 8'h14
`define OLC_REG_TERM_A 8'h18
`define OLC_REG_TERM_B 8'h1c
`define OLC_REG_COMM 8'h20
`define OLC_REG_TIMEOUT 8'h24
`define OLC_REG_STATUS 8'h28
`define OLC_REG_IRQ_STAT 8'h2c
`define OLC_REG_IRQ_MASK 8'h30
`define OLC_REG_LIFE 8'h34

`define OLC_F_A_LSB 0
`define OLC_F_B_LSB 8
`define OLC_F_OP_LSB 16
`define OLC_SEL_STRIDE 8
`define OLC_F_FANCTL_LSB 8
`define OLC_F_OUTS_LSB 16
`define OLC_F_CL_BIT 8
`define OLC_F_FD_BIT 9
`define OLC_LIFE_CAP_BIT 0
`define OLC_LIFE_FAN_BIT 1

`define OLC_OP_AND 2'h0
`define OLC_OP_OR 2'h1
`define OLC_OP_XOR 2'h2
`define OLC_CODE_MAX 6'h38
`define OLC_CODE_COMM_LOSS 6'h20
`define OLC_CODE_LOG_FIRST 6'h21
`define OLC_CODE_LOG_LAST 6'h26
`define OLC_CODE_CAP_LIFE 6'h27
`define OLC_CODE_FAN_DROP 6'h28
`define OLC_FAN_SUPPRESS 2'h1
`define OLC_FAN_NUM 18'h00003
`define OLC_FAN_DEN 18'h00004

`define OLC_CLK_NS 40
`define OLC_TICK_NS 10000000
`define OLC_TIMEOUT_MAX 14'h270f

`define OLC_RESP_OKAY 2'h0
`define OLC_RESP_SLVERR 2'h2

`endif

/* File: olc_combiner.sv */
// output signal logic combiner: six logic units, output routing, comm-loss and fan-drop flags
//
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`include "olc_cfg.svh"

// Summary of operation
// - six units, each combining two operands
// - operator 00 AND, 01 OR, 02 XOR
// - logic results never feed back as operands
// - operand codes 00 through 56 select status
// - each unit has its own three settings
// - codes 33..38 route results one to six
// - five terminals and relay route independently
// - comm-loss only when Modbus RTU selected
// - timeout sets comm-loss until next data
// - timeout limit 0.00 to 99.99 seconds
// - code 32 routes comm-loss flag
// - fan flag below about 75 percent speed
// - fan control 01 suppresses fan flag
// - code 40 routes fan drop flag
// - fan flag readable in life-check monitor
// - capacitor life warning never generated
module olc_combiner #(
  parameter int TICK_CYCLES = `OLC_TICK_NS / `OLC_CLK_NS
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  // axi4-lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read address
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  // axi4-lite read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // drive status signals, indexed by function code
  input wire logic [56:0] status_in,
  // serial reception and fan sensing
  input wire logic rx_data_strobe,
  input wire logic [15:0] fan_speed,
  input wire logic [15:0] fan_nominal,
  // routed outputs
  output logic [4:0] terminal_out,
  output logic relay_out,
  output logic irq
);

  olc_pkg::olc_state_t s;
  olc_pkg::olc_state_t n;

  // operand pick: result codes read as zero so no loop can form
  function automatic logic pick_operand(input logic [5:0] code, input logic [56:0] st,
                                        input logic cl, input logic fd);
    logic v;
    v = 1'b0;
    if (code > `OLC_CODE_MAX) begin
      v = 1'b0;
    end else if (code >= `OLC_CODE_LOG_FIRST && code <= `OLC_CODE_LOG_LAST) begin
      v = 1'b0;
    end else if (code == `OLC_CODE_COMM_LOSS) begin
      v = cl;
    end else if (code == `OLC_CODE_FAN_DROP) begin
      v = fd;
    end else if (code == `OLC_CODE_CAP_LIFE) begin
      v = 1'b0;
    end else begin
      v = st[code];
    end
    return v;
  endfunction

  // output pick adds the six unit results to the operand set
  function automatic logic pick_output(input logic [5:0] code, input logic [56:0] st,
                                       input logic cl, input logic fd, input logic [5:0] res);
    logic v;
    logic [5:0] idx;
    idx = code - `OLC_CODE_LOG_FIRST;
    if (code >= `OLC_CODE_LOG_FIRST && code <= `OLC_CODE_LOG_LAST) begin
      v = res[idx[2:0]];
    end else begin
      v = pick_operand(code, st, cl, fd);
    end
    return v;
  endfunction

  function automatic logic combine(input logic [1:0] op, input logic x, input logic y);
    logic v;
    case (op)
      `OLC_OP_AND: v = x & y;
      `OLC_OP_OR: v = x | y;
      `OLC_OP_XOR: v = x ^ y;
      // reserved operator code drives a steady low rather than guessing
      default: v = 1'b0;
    endcase
    return v;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] v;
    v = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        v[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return v;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a[1:0] == 2'h0 && a <= `OLC_REG_LIFE;
  endfunction

  function automatic logic unit_reg(input logic [7:0] a);
    return a <= `OLC_REG_UNIT_LAST;
  endfunction

  function automatic logic [2:0] unit_of(input logic [7:0] a);
    return a[4:2];
  endfunction

  // unmapped or misaligned words answer with a slave error
  function automatic logic [1:0] resp_of(input logic [7:0] a);
    return mapped(a) ? `OLC_RESP_OKAY : `OLC_RESP_SLVERR;
  endfunction

  function automatic logic tick_wrap(input logic [23:0] cnt);
    return cnt >= 24'(TICK_CYCLES - 1);
  endfunction

  // only the low 14 bits are used; if those bits exceed 9999 (99.99 s) the limit saturates there
  function automatic logic [13:0] clamp_limit(input logic [31:0] d);
    logic [13:0] v;
    if (d[13:0] > `OLC_TIMEOUT_MAX) begin
      v = `OLC_TIMEOUT_MAX;
    end else begin
      v = d[13:0];
    end
    return v;
  endfunction

  function automatic olc_pkg::olc_unit_cfg_t unit_from_word(input logic [31:0] d);
    olc_pkg::olc_unit_cfg_t c;
    c.a = d[`OLC_F_A_LSB +: 6];
    c.b = d[`OLC_F_B_LSB +: 6];
    c.op = d[`OLC_F_OP_LSB +: 2];
    return c;
  endfunction

  // current register image, shared by reads and by byte-merged writes
  function automatic logic [31:0] reg_image(input olc_pkg::olc_state_t st, input logic [7:0] a);
    logic [31:0] v;
    logic [2:0] u;
    v = 32'h0;
    u = unit_of(a);
    if (unit_reg(a)) begin
      v[`OLC_F_A_LSB +: 6] = st.unit[u].a;
      v[`OLC_F_B_LSB +: 6] = st.unit[u].b;
      v[`OLC_F_OP_LSB +: 2] = st.unit[u].op;
    end else begin
      case (a)
        `OLC_REG_TERM_A: begin
          for (int i = 0; i < 4; i++) begin
            v[i*`OLC_SEL_STRIDE +: 6] = st.out_sel[i];
          end
        end
        `OLC_REG_TERM_B: begin
          v[0 +: 6] = st.out_sel[4];
          v[`OLC_SEL_STRIDE +: 6] = st.out_sel[5];
        end
        `OLC_REG_COMM: begin
          v[0] = st.modbus_rtu;
          v[`OLC_F_FANCTL_LSB +: 2] = st.fan_ctl;
        end
        `OLC_REG_TIMEOUT: v[13:0] = st.timeout_limit;
        `OLC_REG_STATUS: begin
          v[5:0] = st.results;
          v[`OLC_F_CL_BIT] = st.comm_loss;
          v[`OLC_F_FD_BIT] = st.fan_drop;
          v[`OLC_F_OUTS_LSB +: 6] = st.outs;
        end
        `OLC_REG_IRQ_STAT: v[1:0] = st.irq_status;
        `OLC_REG_IRQ_MASK: v[1:0] = st.irq_mask;
        `OLC_REG_LIFE: begin
          v[`OLC_LIFE_CAP_BIT] = 1'b0;
          v[`OLC_LIFE_FAN_BIT] = st.fan_drop;
        end
        default: v = 32'h0;
      endcase
    end
    return v;
  endfunction

  logic do_write;
  logic [31:0] wr_val;
  logic [17:0] fan_lhs;
  logic [17:0] fan_rhs;
  logic [1:0] irq_set;

  // a pending response blocks both channels, so at most one write is in flight
  assign awready = !s.axi.aw_full && !s.axi.bvalid;
  assign wready = !s.axi.w_full && !s.axi.bvalid;
  assign arready = !s.axi.rvalid;
  assign bvalid = s.axi.bvalid;
  assign bresp = s.axi.bresp;
  assign rvalid = s.axi.rvalid;
  assign rdata = s.axi.rdata;
  assign rresp = s.axi.rresp;
  assign terminal_out = s.outs[4:0];
  assign relay_out = s.outs[5];
  assign irq = |(s.irq_status & s.irq_mask);

  always_comb begin
    n = s;
    do_write = s.axi.aw_full && s.axi.w_full && !s.axi.bvalid;
    wr_val = merge(reg_image(s, s.axi.awaddr), s.axi.wdata, s.axi.wstrb);
    fan_lhs = {2'h0, fan_speed} * `OLC_FAN_DEN;
    fan_rhs = {2'h0, fan_nominal} * `OLC_FAN_NUM;
    irq_set = 2'h0;

    // axi write: address and data may arrive in either order
    if (awvalid && awready) begin
      n.axi.aw_full = 1'b1;
      n.axi.awaddr = awaddr;
    end
    if (wvalid && wready) begin
      n.axi.w_full = 1'b1;
      n.axi.wdata = wdata;
      n.axi.wstrb = wstrb;
    end
    if (do_write) begin
      n.axi.aw_full = 1'b0;
      n.axi.w_full = 1'b0;
      n.axi.bvalid = 1'b1;
      n.axi.bresp = resp_of(s.axi.awaddr);
    end
    if (s.axi.bvalid && bready) begin
      n.axi.bvalid = 1'b0;
    end
    if (arvalid && arready) begin
      n.axi.rvalid = 1'b1;
      n.axi.rdata = mapped(araddr) ? reg_image(s, araddr) : 32'h0;
      n.axi.rresp = resp_of(araddr);
    end
    if (s.axi.rvalid && rready) begin
      n.axi.rvalid = 1'b0;
    end

    // logic units: registered once per clock from the live operands
    for (int u = 0; u < 6; u++) begin
      n.results[u] = combine(s.unit[u].op,
                             pick_operand(s.unit[u].a, status_in, s.comm_loss, s.fan_drop),
                             pick_operand(s.unit[u].b, status_in, s.comm_loss, s.fan_drop));
    end
    // outputs use last cycle's results, so a routed result lags its operands by two clocks
    for (int o = 0; o < 6; o++) begin
      n.outs[o] = pick_output(s.out_sel[o], status_in, s.comm_loss, s.fan_drop, s.results);
    end

    // fan drop: compare speed against three quarters of nominal
    n.fan_drop = (fan_lhs < fan_rhs) && (s.fan_ctl != `OLC_FAN_SUPPRESS);

    // reception timeout in 10 ms steps; a zero limit disables the watch
    if (!s.modbus_rtu || s.timeout_limit == 14'h0) begin
      n.tick_cnt = 24'h0;
      n.timeout_cnt = 14'h0;
      n.comm_loss = 1'b0;
    end else if (rx_data_strobe) begin
      // a strobe held high keeps the watch cleared
      n.tick_cnt = 24'h0;
      n.timeout_cnt = 14'h0;
      n.comm_loss = 1'b0;
    end else if (!s.comm_loss) begin
      if (tick_wrap(s.tick_cnt)) begin
        n.tick_cnt = 24'h0;
        n.timeout_cnt = s.timeout_cnt + 14'h1;
        if (n.timeout_cnt >= s.timeout_limit) begin
          n.comm_loss = 1'b1;
        end
      end else begin
        n.tick_cnt = s.tick_cnt + 24'h1;
      end
    end

    // rising edges only: a flag that stays up raises the interrupt once
    irq_set[0] = n.comm_loss && !s.comm_loss;
    irq_set[1] = n.fan_drop && !s.fan_drop;

    // register writes; each unit keeps a private word
    // partial strobes merge into the live image, so untouched fields keep their settings
    if (do_write && mapped(s.axi.awaddr)) begin
      if (unit_reg(s.axi.awaddr)) begin
        n.unit[unit_of(s.axi.awaddr)] = unit_from_word(wr_val);
      end else begin
        case (s.axi.awaddr)
          `OLC_REG_TERM_A: begin
            for (int i = 0; i < 4; i++) begin
              n.out_sel[i] = wr_val[i*`OLC_SEL_STRIDE +: 6];
            end
          end
          `OLC_REG_TERM_B: begin
            n.out_sel[4] = wr_val[0 +: 6];
            n.out_sel[5] = wr_val[`OLC_SEL_STRIDE +: 6];
          end
          `OLC_REG_COMM: begin
            n.modbus_rtu = wr_val[0];
            n.fan_ctl = wr_val[`OLC_F_FANCTL_LSB +: 2];
          end
          `OLC_REG_TIMEOUT: begin
            n.timeout_limit = clamp_limit(wr_val);
          end
          `OLC_REG_IRQ_STAT: n.irq_status = s.irq_status & ~wr_val[1:0];
          `OLC_REG_IRQ_MASK: n.irq_mask = wr_val[1:0];
          default: n.irq_mask = n.irq_mask;
        endcase
      end
    end
    // a new event beats a clear in the same cycle
    n.irq_status = n.irq_status | irq_set;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

endmodule

/* File: olc_combiner_sva.sv */
// bus handshake and reset checks of the combiner
`include "olc_cfg.svh"
module olc_combiner_sva (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write side
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  // read side
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  // routed outputs
  input wire logic [4:0] terminal_out,
  input wire logic relay_out,
  input wire logic irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_read_answer: assert property (arvalid && arready |=> rvalid) else $error("read not answered");
  a_read_excl: assert property (rvalid |-> !arready) else $error("read address taken while busy");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data dropped early");
  a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write not answered");
  a_write_excl: assert property (bvalid |-> !awready && !wready) else $error("write taken while busy");
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("bresp dropped");
  a_resp_legal: assert property (rvalid |-> rresp == `OLC_RESP_OKAY || rresp == `OLC_RESP_SLVERR)
    else $error("bad read response");
  a_reset_quiet: assert property ($rose(aresetn) |-> !bvalid && !rvalid && !irq && !relay_out
    && terminal_out == 5'h0) else $error("outputs not cleared by reset");
endmodule
bind olc_combiner olc_combiner_sva olc_combiner_sva_i (.*);

/* File: olc_far_end.sv */
// far-end equipment: latches the five terminals and the relay every clock
module olc_far_end (
  // clock
  input wire logic aclk,
  // lines from the drive
  input wire logic [4:0] terminal_out,
  input wire logic relay_out,
  // what the equipment saw, relay on top
  output logic [5:0] seen
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge aclk) begin
    seen <= {relay_out, terminal_out};
  end
endmodule

/* File: olc_pkg.sv */
// types of the output logic combiner
package olc_pkg;

  typedef struct packed {
    logic [1:0] op;
    logic [5:0] b;
    logic [5:0] a;
  } olc_unit_cfg_t;

  typedef struct packed {
    logic aw_full;
    logic w_full;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } olc_axi_t;

  typedef struct packed {
    olc_unit_cfg_t [5:0] unit;
    logic [5:0][5:0] out_sel;
    logic modbus_rtu;
    logic [1:0] fan_ctl;
    logic [13:0] timeout_limit;
    logic [23:0] tick_cnt;
    logic [13:0] timeout_cnt;
    logic comm_loss;
    logic fan_drop;
    logic [5:0] results;
    logic [5:0] outs;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    olc_axi_t axi;
  } olc_state_t;

endpackage

/* File: output_signal_logic_combiner_tb_top.sv */
// random and corner-case bench of the combiner
`include "olc_cfg.svh"
module output_signal_logic_combiner_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0, rx_data_strobe = 1'h0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [2:0] awprot = '0, arprot = '0;
  logic [31:0] wdata = '0, got;
  logic [3:0] wstrb = 4'hf;
  logic [56:0] status_in = '0, s;
  logic [15:0] fan_speed = 16'h0064, fan_nominal = 16'h0064;
  logic awready, wready, bvalid, arready, rvalid, relay_out, irq;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata;
  logic [4:0] terminal_out;
  logic [5:0] seen, ev, t;
  logic [5:0] ca [6] = '{default: '0};
  logic [5:0] cb [6] = '{default: '0};
  logic [1:0] co [6] = '{default: '0};
  int err_total = 0, n_checks = 0, u;
  // short tick keeps the comm-loss watch within a few dozen cycles
  olc_combiner #(.TICK_CYCLES(4)) olc_combiner_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awprot(awprot), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(arprot),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .status_in(status_in), .rx_data_strobe(rx_data_strobe), .fan_speed(fan_speed), .fan_nominal(fan_nominal),
    .terminal_out(terminal_out), .relay_out(relay_out), .irq(irq));
  olc_far_end olc_far_end_i (.aclk(aclk), .terminal_out(terminal_out), .relay_out(relay_out), .seen(seen));
  always #20 aclk = ~aclk;
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // ready is raised only after the answer shows, so the hold rules get exercised
  task automatic wr(logic [7:0] ad, logic [31:0] d);
    int n;
    awaddr <= ad;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid && bready) begin
        resp = bresp;
        bready <= 1'h0;
        break;
      end
      if (bvalid) bready <= 1'h1;
    end
    if (n == 40) begin
      err_total++;
      conclude();
    end
  endtask
  task automatic rd(logic [7:0] ad);
    int n;
    araddr <= ad;
    arvalid <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid && rready) begin
        got = rdata;
        resp = rresp;
        rready <= 1'h0;
        break;
      end
      if (rvalid) rready <= 1'h1;
    end
    if (n == 40) begin
      err_total++;
      conclude();
    end
  endtask
  task automatic rdc(string nm, logic [7:0] ad, logic [31:0] e);
    rd(ad);
    chk(nm, e, got);
  endtask
  task automatic hold_chk(string nm, int k, logic e);
    repeat (20) @(posedge aclk);
    chk(nm, 32'(e), 32'(seen[k]));
  endtask
  // operand value: flags are quiet in the random phase, results never feed back
  function automatic logic sg(logic [5:0] c, logic [56:0] v);
    return (c < 6'h20 || (c > 6'h28 && c <= `OLC_CODE_MAX)) ? v[c] : 1'h0;
  endfunction
  function automatic logic opf(logic [1:0] o, logic x, logic y);
    case (o)
      `OLC_OP_OR: return x | y;
      `OLC_OP_XOR: return x ^ y;
      default: return x & y;
    endcase
  endfunction
  function automatic logic [5:0] expv(logic [56:0] v);
    logic [5:0] r;
    for (int k = 0; k < 6; k++) r[k] = opf(co[k], sg(ca[k], v), sg(cb[k], v));
    return r;
  endfunction
  initial begin
    void'($urandom(61889));
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    rdc("status", `OLC_REG_STATUS, 32'h0);
    rdc("life", `OLC_REG_LIFE, 32'h0);
    rdc("unmapped", 8'h38, 32'h0);
    chk("rresp", 32'h2, 32'(resp));
    wr(8'h3c, 32'hffffffff);
    chk("bresp", 32'h2, 32'(resp));
    for (int i = 0; i < 18; i++) begin
      u = $urandom % 6;
      ca[u] = (i == 0) ? 6'h21 : 6'($urandom % 57);
      cb[u] = 6'($urandom % 57);
      co[u] = 2'(i % 3);
      t = 6'(41 + i % 16);
      s = {25'($urandom), $urandom};
      wr(`OLC_REG_UNIT_FIRST + 8'(4 * u), {14'h0, co[u], 2'h0, cb[u], 2'h0, ca[u]});
      wr(`OLC_REG_TERM_A, {18'h0, 6'(33 + u), 2'h0, t});
      status_in <= s;
      repeat (4) @(posedge aclk);
      ev = expv(s);
      rd(`OLC_REG_STATUS);
      chk("results", 32'(ev), 32'(got[5:0]));
      chk("unit route", 32'(ev[u]), 32'(seen[1]));
      chk("direct route", 32'(s[t]), 32'(seen[0]));
    end
    wr(`OLC_REG_TERM_B, {18'h0, `OLC_CODE_FAN_DROP, 2'h0, `OLC_CODE_COMM_LOSS});
    wr(`OLC_REG_IRQ_MASK, 32'h2);
    fan_speed <= 16'h004b;
    hold_chk("fan at 75", 5, 1'h0);
    chk("irq quiet", 32'h0, 32'(irq));
    fan_speed <= 16'h004a;
    hold_chk("fan below 75", 5, 1'h1);
    chk("irq raised", 32'h1, 32'(irq));
    rdc("life", `OLC_REG_LIFE, 32'h2);
    wr(`OLC_REG_UNIT_FIRST, {14'h0, `OLC_OP_XOR, 2'h0, `OLC_CODE_CAP_LIFE, 2'h0, `OLC_CODE_FAN_DROP});
    wr(`OLC_REG_TERM_A, {18'h0, `OLC_CODE_LOG_FIRST, 2'h0, `OLC_CODE_CAP_LIFE});
    hold_chk("fan operand", 1, 1'h1);
    chk("cap life route", 32'h0, 32'(seen[0]));
    wr(`OLC_REG_IRQ_STAT, 32'h3);
    chk("irq cleared", 32'h0, 32'(irq));
    wr(`OLC_REG_COMM, 32'h100);
    hold_chk("fan suppressed", 5, 1'h0);
    wr(`OLC_REG_TIMEOUT, 32'hffff);
    rdc("limit clamp", `OLC_REG_TIMEOUT, 32'h270f);
    wstrb <= 4'h1;
    wr(`OLC_REG_TIMEOUT, 32'hffffff05);
    wstrb <= 4'hf;
    rdc("byte merge", `OLC_REG_TIMEOUT, 32'h2705);
    wr(`OLC_REG_TIMEOUT, 32'h2);
    wr(`OLC_REG_COMM, 32'h101);
    hold_chk("comm loss", 4, 1'h1);
    rx_data_strobe <= 1'h1;
    @(posedge aclk);
    rx_data_strobe <= 1'h0;
    repeat (3) @(posedge aclk);
    chk("comm restored", 32'h0, 32'(seen[4]));
    wr(`OLC_REG_COMM, 32'h100);
    hold_chk("comm no modbus", 4, 1'h0);
    // mid-run reset must clear the unit 0, timeout and mask settings again
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    rdc("unit after reset", `OLC_REG_UNIT_FIRST, 32'h0);
    rdc("timeout after reset", `OLC_REG_TIMEOUT, 32'h0);
    rdc("mask after reset", `OLC_REG_IRQ_MASK, 32'h0);
    conclude();
  end
endmodule
